// >>> design/lom_pkg.sv
// Purpose: constants shared by the lane output configuration registers
// Assumes: byte-wide register port, one output lane
// Notes:   register offsets are byte addresses on the register port
package lom_pkg;

  // ****************************************************************
  // register map
  // ****************************************************************
  localparam logic [7:0] LOM_ADDR_IDLE_RATE = 8'h40;
  localparam logic [7:0] LOM_ADDR_SWING     = 8'h42;
  localparam logic [7:0] LOM_ADDR_DEEMPH    = 8'h43;
  localparam logic [7:0] LOM_ADDR_GADJ      = 8'h47;

  localparam logic [7:0] LOM_RST_IDLE_RATE  = 8'h00;
  localparam logic [7:0] LOM_RST_SWING      = 8'h03;
  localparam logic [7:0] LOM_RST_DEEMPH     = 8'h03;
  localparam logic [7:0] LOM_RST_GADJ       = 8'h02;
  localparam logic [7:0] LOM_RDATA_UNMAPPED = 8'h00;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int LOM_BIT_IDLE_AUTO = 5;
  localparam int LOM_BIT_IDLE_SEL  = 4;
  localparam int LOM_BIT_RATE_AUTO = 1;
  localparam int LOM_BIT_RATE_SEL  = 0;
  localparam int LOM_BIT_DEM_TYPE  = 7;
  localparam int LOM_SWING_MSB     = 6;
  localparam int LOM_DEM_LVL_MSB   = 6;
  localparam int LOM_GADJ_MSB      = 1;

  // ****************************************************************
  // output swing codes and amplitudes in mV
  // ****************************************************************
  localparam logic [6:0]  LOM_SWING_600  = 7'h03;
  localparam logic [6:0]  LOM_SWING_800  = 7'h07;
  localparam logic [6:0]  LOM_SWING_1000 = 7'h0f;
  localparam logic [6:0]  LOM_SWING_1200 = 7'h1f;
  localparam logic [10:0] LOM_MV_600     = 11'h258;
  localparam logic [10:0] LOM_MV_800     = 11'h320;
  localparam logic [10:0] LOM_MV_1000    = 11'h3e8;
  localparam logic [10:0] LOM_MV_1200    = 11'h4b0;

  // ****************************************************************
  // de-emphasis codes and attenuation in tenths of a dB
  // ****************************************************************
  localparam logic [7:0] LOM_DEM_0DB0  = 8'h01;
  localparam logic [7:0] LOM_DEM_3DB5  = 8'he8;
  localparam logic [7:0] LOM_DEM_6DB0  = 8'h88;
  localparam logic [7:0] LOM_DEM_9DB0  = 8'h90;
  localparam logic [7:0] LOM_DEM_12DB0 = 8'ha0;
  localparam logic [6:0] LOM_TDB_0     = 7'h00;
  localparam logic [6:0] LOM_TDB_35    = 7'h23;
  localparam logic [6:0] LOM_TDB_60    = 7'h3c;
  localparam logic [6:0] LOM_TDB_90    = 7'h5a;
  localparam logic [6:0] LOM_TDB_120   = 7'h78;

  // ****************************************************************
  // global swing scale in eighths
  // ****************************************************************
  localparam logic [1:0] LOM_GADJ_M250 = 2'h0;
  localparam logic [1:0] LOM_GADJ_M125 = 2'h1;
  localparam logic [1:0] LOM_GADJ_P000 = 2'h2;
  localparam logic [1:0] LOM_GADJ_P125 = 2'h3;
  localparam logic [3:0] LOM_EIGHTHS_M250 = 4'h6;
  localparam logic [3:0] LOM_EIGHTHS_M125 = 4'h7;
  localparam logic [3:0] LOM_EIGHTHS_P000 = 4'h8;
  localparam logic [3:0] LOM_EIGHTHS_P125 = 4'h9;
  localparam int         LOM_EIGHTHS_SHIFT = 3;

endpackage

// >>> design/lom_regs.sv
// Purpose: configuration registers of one output lane of a mux/buffer
// Assumes: byte register port driven by the management interface logic
// Notes:   all outputs registered; reserved bits stored but unused
//          mirrored outputs follow a write at its own edge
//          derived outputs follow one edge after the register
//          detector changes reach the outputs about five edges late
//
// Behaviour
// - With idle-auto set the lane mutes from its own idle detector, else the manual idle bit decides.
// - Under manual idle a 0 keeps the output on with detection off and a 1 mutes it.
// - With rate-auto set the detected rate is used, else the manual rate bit sets the range.
// - The swing code gives 600, 800, 1000 or 1200 mV and code 3Fh is reserved.
// - De-emphasis bit 7 picks compatibility or enhanced type and bits 6 to 0 the level.
// - De-emphasis codes 01h, E8h, 88h, 90h, A0h give 0, -3.5, -6, -9, -12 dB, reset 03h.
// - The global adjust scales every swing by -25, -12.5, 0 or +12.5 percent, reset 10.
`timescale 1ns/1ps
module lom_regs
  import lom_pkg::*;
(
  input  wire logic        ref_clk_i,
  input  wire logic        resetn_i,
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic        reg_wr_i,
  input  wire logic [7:0]  reg_wdata_i,
  input  wire logic        reg_rd_i,
  output logic      [7:0]  reg_rdata_o,
  output logic             reg_rvalid_o,
  input  wire logic        idle_detected_i,
  input  wire logic        rate_high_detected_i,
  output logic             mute_o,
  output logic             signal_detection_en_o,
  output logic             rate_high_o,
  output logic      [6:0]  output_swing_code_o,
  output logic      [10:0] output_swing_mv_o,
  output logic             output_swing_reserved_o,
  output logic      [1:0]  output_swing_adjust_o,
  output logic             deemphasis_type_o,
  output logic      [6:0]  deemphasis_level_o,
  output logic      [6:0]  deemphasis_tenth_db_o,
  output logic             deemphasis_unlisted_o
);

  typedef struct packed {
    logic [7:0]  idle_rate;
    logic [7:0]  swing;
    logic [7:0]  deemph;
    logic [7:0]  gadj;
    logic [7:0]  rdata;
    logic        rvalid;
    logic        mute;
    logic        sd_en;
    logic        rate_high;
    logic [10:0] swing_mv;
    logic        swing_bad;
    logic [6:0]  dem_tdb;
    logic        dem_bad;
  } lom_regs_state_type;

  lom_regs_state_type state_reg;
  lom_regs_state_type state_next;
  logic [1:0]         det_sync;

  // ****************************************************************
  // detector synchronisers
  // ****************************************************************
  lom_sync #(
    .WIDTH (2)
  ) u_sync (
    .ref_clk_i (ref_clk_i),
    .resetn_i  (resetn_i),
    .async_i   ({rate_high_detected_i, idle_detected_i}),
    .sync_o    (det_sync)
  );

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    logic [7:0]  ir;
    logic [6:0]  sc;
    logic [10:0] base_mv;
    logic [3:0]  eighths;
    logic [14:0] prod;
    ir         = '0;
    sc         = '0;
    base_mv    = '0;
    eighths    = '0;
    prod       = '0;
    state_next = state_reg;

    // **************************************************************
    // register writes, reserved bits kept as written
    // **************************************************************
    if (reg_wr_i) begin
      unique case (reg_addr_i)
        LOM_ADDR_IDLE_RATE: state_next.idle_rate = reg_wdata_i;
        LOM_ADDR_SWING:     state_next.swing     = reg_wdata_i;
        LOM_ADDR_DEEMPH:    state_next.deemph    = reg_wdata_i;
        LOM_ADDR_GADJ:      state_next.gadj      = reg_wdata_i;
        default: ;
      endcase
    end

    // **************************************************************
    // register reads, one cycle later
    // **************************************************************
    // read and write in one cycle returns the old value
    state_next.rvalid = reg_rd_i;
    if (reg_rd_i) begin
      unique case (reg_addr_i)
        LOM_ADDR_IDLE_RATE: state_next.rdata = state_reg.idle_rate;
        LOM_ADDR_SWING:     state_next.rdata = state_reg.swing;
        LOM_ADDR_DEEMPH:    state_next.rdata = state_reg.deemph;
        LOM_ADDR_GADJ:      state_next.rdata = state_reg.gadj;
        default:            state_next.rdata = LOM_RDATA_UNMAPPED;
      endcase
    end

    // **************************************************************
    // idle control from current register contents
    // **************************************************************
    // detector levels arrive through the three-flop filter
    ir = state_reg.idle_rate;
    if (ir[LOM_BIT_IDLE_AUTO]) begin
      state_next.sd_en = 1'b1;
      state_next.mute  = det_sync[0];
    end else begin
      state_next.sd_en = 1'b0;
      state_next.mute  = ir[LOM_BIT_IDLE_SEL];
    end

    // **************************************************************
    // rate range control
    // **************************************************************
    if (ir[LOM_BIT_RATE_AUTO]) begin
      state_next.rate_high = det_sync[1];
    end else begin
      state_next.rate_high = ir[LOM_BIT_RATE_SEL];
    end

    // **************************************************************
    // swing amplitude; unlisted codes keep the default amplitude
    // **************************************************************
    sc                   = state_reg.swing[LOM_SWING_MSB:0];
    state_next.swing_bad = 1'b0;
    unique case (sc)
      LOM_SWING_600:  base_mv = LOM_MV_600;
      LOM_SWING_800:  base_mv = LOM_MV_800;
      LOM_SWING_1000: base_mv = LOM_MV_1000;
      LOM_SWING_1200: base_mv = LOM_MV_1200;
      default: begin
        base_mv              = LOM_MV_600;
        state_next.swing_bad = 1'b1;
      end
    endcase

    // **************************************************************
    // global scale in eighths
    // **************************************************************
    unique case (state_reg.gadj[LOM_GADJ_MSB:0])
      LOM_GADJ_M250: eighths = LOM_EIGHTHS_M250;
      LOM_GADJ_M125: eighths = LOM_EIGHTHS_M125;
      LOM_GADJ_P000: eighths = LOM_EIGHTHS_P000;
      LOM_GADJ_P125: eighths = LOM_EIGHTHS_P125;
    endcase
    prod                = 15'(base_mv) * 15'(eighths);
    state_next.swing_mv = 11'(prod >> LOM_EIGHTHS_SHIFT);

    // **************************************************************
    // de-emphasis attenuation from the whole register
    // **************************************************************
    state_next.dem_bad = 1'b0;
    unique case (state_reg.deemph)
      LOM_DEM_0DB0:  state_next.dem_tdb = LOM_TDB_0;
      LOM_DEM_3DB5:  state_next.dem_tdb = LOM_TDB_35;
      LOM_DEM_6DB0:  state_next.dem_tdb = LOM_TDB_60;
      LOM_DEM_9DB0:  state_next.dem_tdb = LOM_TDB_90;
      LOM_DEM_12DB0: state_next.dem_tdb = LOM_TDB_120;
      default: begin
        state_next.dem_tdb = LOM_TDB_0;
        state_next.dem_bad = 1'b1;
      end
    endcase
  end

  // ****************************************************************
  // state register
  // ****************************************************************
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_reg           <= '0;
      state_reg.idle_rate <= LOM_RST_IDLE_RATE;
      state_reg.swing     <= LOM_RST_SWING;
      state_reg.deemph    <= LOM_RST_DEEMPH;
      state_reg.gadj      <= LOM_RST_GADJ;
      state_reg.swing_mv  <= LOM_MV_600;
      state_reg.dem_bad   <= 1'b1;
      state_reg.swing_bad <= 1'b0;
      state_reg.dem_tdb   <= LOM_TDB_0;
      state_reg.rdata     <= LOM_RDATA_UNMAPPED;
    end else begin
      state_reg <= state_next;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign reg_rdata_o             = state_reg.rdata;
  assign reg_rvalid_o            = state_reg.rvalid;
  assign mute_o                  = state_reg.mute;
  assign signal_detection_en_o   = state_reg.sd_en;
  assign rate_high_o             = state_reg.rate_high;
  assign output_swing_code_o     = state_reg.swing[LOM_SWING_MSB:0];
  assign output_swing_mv_o       = state_reg.swing_mv;
  assign output_swing_reserved_o = state_reg.swing_bad;
  assign output_swing_adjust_o   = state_reg.gadj[LOM_GADJ_MSB:0];
  assign deemphasis_type_o       = state_reg.deemph[LOM_BIT_DEM_TYPE];
  assign deemphasis_level_o      = state_reg.deemph[LOM_DEM_LVL_MSB:0];
  assign deemphasis_tenth_db_o   = state_reg.dem_tdb;
  assign deemphasis_unlisted_o   = state_reg.dem_bad;

endmodule // lom_regs

// >>> design/lom_sync.sv
// Purpose: three-stage synchroniser with agreement filter
// Assumes: inputs are asynchronous levels from the analog detectors
// Notes:   output follows only when stages two and three agree
`timescale 1ns/1ps
module lom_sync #(
  parameter int WIDTH = 2
) (
  input  wire logic             ref_clk_i,
  input  wire logic             resetn_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] q;
  } lom_sync_state_type;

  lom_sync_state_type state_reg;
  lom_sync_state_type state_next;

  always_comb begin
    state_next    = state_reg;
    state_next.s1 = async_i;
    state_next.s2 = state_reg.s1;
    state_next.s3 = state_reg.s2;
    for (int i = 0; i < WIDTH; i++) begin
      if (state_reg.s2[i] == state_reg.s3[i]) begin
        state_next.q[i] = state_reg.s3[i];
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign sync_o = state_reg.q;

endmodule // lom_sync

// >>> verification/lane_output_config_regs_tb.sv
// Purpose: self-checking bench for the lane output configuration registers
// Assumes: inputs driven on the falling edge
// Notes:   detector inputs are held steady long enough to pass the sync
`timescale 1ns/1ps
module lane_output_config_regs_tb
  import lom_pkg::*;
  ;
  logic        ref_clk_i = 1'b0;
  logic        resetn_i = 1'b0;
  logic [7:0]  reg_addr_i = 8'h00;
  logic [7:0]  reg_wdata_i = 8'h00;
  logic        reg_wr_i = 1'b0;
  logic        reg_rd_i = 1'b0;
  logic        idle_detected_i = 1'b0;
  logic        rate_high_detected_i = 1'b0;
  logic [7:0]  reg_rdata_o;
  logic        reg_rvalid_o, mute_o, sd_o, rate_high_o, sw_res_o;
  logic        dem_type_o, dem_unl_o;
  logic [6:0]  sw_code_o, dem_lvl_o, dem_tdb_o;
  logic [10:0] sw_mv_o;
  logic [1:0]  sw_adj_o;
  int          n_errors = 0;
  int          samples_checked = 0;
  int          cycles = 0;
  int          base[4] = '{600, 800, 1000, 1200};
  logic [6:0]  codes[4] = '{LOM_SWING_600, LOM_SWING_800, LOM_SWING_1000,
                            LOM_SWING_1200};
  logic [7:0]  dcode[5] = '{LOM_DEM_0DB0, LOM_DEM_3DB5, LOM_DEM_6DB0,
                            LOM_DEM_9DB0, LOM_DEM_12DB0};
  logic [6:0]  dtdb[5] = '{LOM_TDB_0, LOM_TDB_35, LOM_TDB_60, LOM_TDB_90,
                           LOM_TDB_120};

  lom_regs dut (
    .ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .reg_addr_i(reg_addr_i),
    .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o),
    .idle_detected_i(idle_detected_i),
    .rate_high_detected_i(rate_high_detected_i), .mute_o(mute_o),
    .signal_detection_en_o(sd_o), .rate_high_o(rate_high_o),
    .output_swing_code_o(sw_code_o), .output_swing_mv_o(sw_mv_o),
    .output_swing_reserved_o(sw_res_o), .output_swing_adjust_o(sw_adj_o),
    .deemphasis_type_o(dem_type_o), .deemphasis_level_o(dem_lvl_o),
    .deemphasis_tenth_db_o(dem_tdb_o), .deemphasis_unlisted_o(dem_unl_o));

  initial forever #5 ref_clk_i = ~ref_clk_i;

  task automatic complete_run();
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  always @(posedge ref_clk_i) begin
    cycles++;
    if (cycles == 3000) begin
      n_errors++;
      complete_run();
    end
  end

  task automatic chk(input string what, input logic [10:0] exp, got);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic settle(input int n);
    repeat (n) @(negedge ref_clk_i);
  endtask

  task automatic wr(input logic [7:0] a, d);
    @(negedge ref_clk_i);
    reg_addr_i = a;
    reg_wdata_i = d;
    reg_wr_i = 1'b1;
    @(negedge ref_clk_i);
    reg_wr_i = 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, exp);
    @(negedge ref_clk_i);
    reg_addr_i = a;
    reg_rd_i = 1'b1;
    @(negedge ref_clk_i);
    reg_rd_i = 1'b0;
    chk("rvalid", 11'h001, 11'(reg_rvalid_o));
    chk("rdata", 11'(exp), 11'(reg_rdata_o));
  endtask

  task automatic t_reset();
    rd_chk(LOM_ADDR_IDLE_RATE, LOM_RST_IDLE_RATE);
    rd_chk(LOM_ADDR_SWING, LOM_RST_SWING);
    rd_chk(LOM_ADDR_DEEMPH, LOM_RST_DEEMPH);
    rd_chk(LOM_ADDR_GADJ, LOM_RST_GADJ);
    chk("swing_mv", LOM_MV_600, sw_mv_o);
    chk("dem_unlisted", 11'h001, 11'(dem_unl_o));
    chk("dem_tdb", 11'(LOM_TDB_0), 11'(dem_tdb_o));
    chk("mute", 11'h000, 11'(mute_o));
    chk("sd_en", 11'h000, 11'(sd_o));
    chk("rate_high", 11'h000, 11'(rate_high_o));
    chk("swing_code", 11'(LOM_SWING_600), 11'(sw_code_o));
    chk("swing_adj", 11'(LOM_GADJ_P000), 11'(sw_adj_o));
    wr(8'h41, 8'h5a);
    rd_chk(8'h41, LOM_RDATA_UNMAPPED);
  endtask

  task automatic t_idle_rate();
    wr(LOM_ADDR_IDLE_RATE, 8'h11);
    settle(1);
    chk("mute", 11'h001, 11'(mute_o));
    chk("sd_en", 11'h000, 11'(sd_o));
    chk("rate_high", 11'h001, 11'(rate_high_o));
    idle_detected_i = 1'b1;
    rate_high_detected_i = 1'b0;
    wr(LOM_ADDR_IDLE_RATE, 8'h00);
    settle(5);
    chk("mute", 11'h000, 11'(mute_o));
    chk("rate_high", 11'h000, 11'(rate_high_o));
    wr(LOM_ADDR_IDLE_RATE, 8'h22);
    rate_high_detected_i = 1'b1;
    settle(5);
    chk("sd_en", 11'h001, 11'(sd_o));
    chk("mute", 11'h001, 11'(mute_o));
    chk("rate_high", 11'h001, 11'(rate_high_o));
    idle_detected_i = 1'b0;
    rate_high_detected_i = 1'b0;
    settle(5);
    chk("mute", 11'h000, 11'(mute_o));
    chk("rate_high", 11'h000, 11'(rate_high_o));
  endtask

  task automatic t_swing();
    for (int i = 0; i < 4; i++) begin
      for (int j = 0; j < 4; j++) begin
        wr(LOM_ADDR_SWING, {1'b0, codes[i]});
        wr(LOM_ADDR_GADJ, {6'h00, 2'(j)});
        settle(1);
        chk("swing_mv", 11'(base[i] * (6 + j) / 8), sw_mv_o);
        chk("swing_res", 11'h000, 11'(sw_res_o));
        chk("swing_code", 11'(codes[i]), 11'(sw_code_o));
        chk("swing_adj", 11'(j), 11'(sw_adj_o));
      end
    end
    wr(LOM_ADDR_SWING, 8'h3f);
    settle(1);
    chk("swing_res", 11'h001, 11'(sw_res_o));
    wr(LOM_ADDR_SWING, 8'h8f);
    wr(LOM_ADDR_GADJ, 8'hfe);
    settle(1);
    rd_chk(LOM_ADDR_SWING, 8'h8f);
    rd_chk(LOM_ADDR_GADJ, 8'hfe);
    chk("swing_mv", LOM_MV_1000, sw_mv_o);
    chk("swing_code", 11'(LOM_SWING_1000), 11'(sw_code_o));
    chk("swing_adj", 11'(LOM_GADJ_P000), 11'(sw_adj_o));
  endtask

  task automatic t_dem();
    for (int k = 0; k < 5; k++) begin
      wr(LOM_ADDR_DEEMPH, dcode[k]);
      settle(1);
      chk("dem_type", 11'(dcode[k][7]), 11'(dem_type_o));
      chk("dem_level", 11'(dcode[k][6:0]), 11'(dem_lvl_o));
      chk("dem_tdb", 11'(dtdb[k]), 11'(dem_tdb_o));
      chk("dem_unlisted", 11'h000, 11'(dem_unl_o));
    end
    wr(LOM_ADDR_DEEMPH, 8'h38);
    settle(1);
    chk("dem_unlisted", 11'h001, 11'(dem_unl_o));
    chk("dem_tdb", 11'(LOM_TDB_0), 11'(dem_tdb_o));
  endtask

  initial begin
    settle(2);
    resetn_i = 1'b1;
    t_reset();
    t_idle_rate();
    t_swing();
    t_dem();
    complete_run();
  end
endmodule // lane_output_config_regs_tb

// >>> verification/lom_regs_assertions.sv
// Purpose: port assertions for the lane output configuration registers
// Assumes: one clock, asynchronous active-low reset
// Notes:   derived outputs lag their registers by one edge
`timescale 1ns/1ps
module lom_regs_assertions
  import lom_pkg::*;
(
  input  wire logic        ref_clk_i,
  input  wire logic        resetn_i,
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic        reg_wr_i,
  input  wire logic [7:0]  reg_wdata_i,
  input  wire logic        reg_rd_i,
  input  wire logic        reg_rvalid_o,
  input  wire logic        idle_detected_i,
  input  wire logic        mute_o,
  input  wire logic        signal_detection_en_o,
  input  wire logic        rate_high_o,
  input  wire logic [6:0]  output_swing_code_o,
  input  wire logic [10:0] output_swing_mv_o,
  input  wire logic [1:0]  output_swing_adjust_o,
  input  wire logic        deemphasis_type_o,
  input  wire logic [6:0]  deemphasis_level_o,
  input  wire logic [6:0]  deemphasis_tenth_db_o,
  input  wire logic        deemphasis_unlisted_o
);
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!resetn_i);
  sequence s_wr_idle;
    reg_wr_i && reg_addr_i == LOM_ADDR_IDLE_RATE;
  endsequence
  sequence s_wr_dem;
    reg_wr_i && reg_addr_i == LOM_ADDR_DEEMPH;
  endsequence
  property p_manual_idle;
    s_wr_idle ##0 !reg_wdata_i[5] |-> ##2
      (mute_o == $past(reg_wdata_i[4], 2) && !signal_detection_en_o);
  endproperty
  a_manual_idle: assert property (p_manual_idle)
    else $error("manual idle bit not reflected on mute");
  property p_auto_idle;
    (signal_detection_en_o && $stable(idle_detected_i))[*6]
      |-> mute_o == idle_detected_i;
  endproperty
  a_auto_idle: assert property (p_auto_idle)
    else $error("mute does not follow idle detector");
  property p_manual_rate;
    s_wr_idle ##0 !reg_wdata_i[1] |-> ##2
      rate_high_o == $past(reg_wdata_i[0], 2);
  endproperty
  a_manual_rate: assert property (p_manual_rate)
    else $error("manual rate bit not reflected");
  property p_swing_code;
    reg_wr_i && reg_addr_i == LOM_ADDR_SWING
      |=> output_swing_code_o == $past(reg_wdata_i[6:0]);
  endproperty
  a_swing_code: assert property (p_swing_code)
    else $error("swing code not stored");
  property p_mv_nominal;
    output_swing_code_o == LOM_SWING_800 &&
      output_swing_adjust_o == LOM_GADJ_P000 |=> output_swing_mv_o == LOM_MV_800;
  endproperty
  a_mv_nominal: assert property (p_mv_nominal)
    else $error("swing amplitude wrong for 800 mV code");
  property p_mv_scaled;
    output_swing_code_o == LOM_SWING_1200 &&
      output_swing_adjust_o == LOM_GADJ_M250 |=> output_swing_mv_o == 11'h384;
  endproperty
  a_mv_scaled: assert property (p_mv_scaled)
    else $error("global adjust scaling wrong");
  property p_dem_fields;
    s_wr_dem |=> {deemphasis_type_o, deemphasis_level_o} == $past(reg_wdata_i);
  endproperty
  a_dem_fields: assert property (p_dem_fields)
    else $error("de-emphasis type or level not stored");
  property p_dem_map;
    {deemphasis_type_o, deemphasis_level_o} == LOM_DEM_3DB5 |=>
      deemphasis_tenth_db_o == LOM_TDB_35 && !deemphasis_unlisted_o;
  endproperty
  a_dem_map: assert property (p_dem_map)
    else $error("de-emphasis level decode wrong");
  property p_rvalid;
    1'b1 |=> reg_rvalid_o == $past(reg_rd_i);
  endproperty
  a_rvalid: assert property (p_rvalid)
    else $error("read valid not one cycle after read");
endmodule // lom_regs_assertions

bind lom_regs lom_regs_assertions u_chk (
  .ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .reg_addr_i(reg_addr_i),
  .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i), .reg_rd_i(reg_rd_i),
  .reg_rvalid_o(reg_rvalid_o), .idle_detected_i(idle_detected_i),
  .mute_o(mute_o), .signal_detection_en_o(signal_detection_en_o),
  .rate_high_o(rate_high_o), .output_swing_code_o(output_swing_code_o),
  .output_swing_mv_o(output_swing_mv_o),
  .output_swing_adjust_o(output_swing_adjust_o),
  .deemphasis_type_o(deemphasis_type_o),
  .deemphasis_level_o(deemphasis_level_o),
  .deemphasis_tenth_db_o(deemphasis_tenth_db_o),
  .deemphasis_unlisted_o(deemphasis_unlisted_o));
